// *** rtl/sd_diag_pkg.sv ***
// package: constants for the serial diagnostic block of the safety switch
package sd_diag_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam longint unsigned CLK_PERIOD_NS = 10;
   localparam longint unsigned WARN_TIME_MIN = 30;
   localparam longint unsigned WARN_CYCLES =
      (WARN_TIME_MIN * 64'd60 * 64'd1000000000) / CLK_PERIOD_NS;
   localparam longint unsigned COMM_TIME_MS = 100;
   localparam longint unsigned COMM_CYCLES = (COMM_TIME_MS * 64'd1000000) / CLK_PERIOD_NS;
   localparam int WARN_W = 38;
   localparam int COMM_W = 24;
   localparam int MAX_CHAIN = 31;

   // ----------------------------------------------------------------
   // byte layouts
   // ----------------------------------------------------------------
   localparam int BYTE_W = 8;
   localparam int REQ_RESET_BIT = 7;
   localparam int RSP_OUT_ON_BIT = 0;
   localparam int RSP_ACTUATOR_BIT = 1;
   localparam int RSP_ENABLES_BIT = 4;
   localparam int RSP_GUARD_BIT = 5;
   localparam int RSP_WARN_BIT = 6;
   localparam int RSP_FAIL_BIT = 7;
   localparam int DG_OUT_ONE_BIT = 0;
   localparam int DG_OUT_TWO_BIT = 1;
   localparam int DG_CROSS_BIT = 2;
   localparam int DG_TEMP_BIT = 3;
   localparam int DG_TARGET_BIT = 4;
   localparam int DG_INTERNAL_BIT = 5;
   localparam int DG_COMM_BIT = 6;
   localparam int DG_VOLT_BIT = 7;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] OUTPUT_FAIL_MASK = 8'h07;

endpackage

// *** rtl/warn_timer.sv ***
// file: delay timer that expires after a warning has persisted
`timescale 1ns/1ns
module warn_timer #(
   parameter logic [37:0] LIMIT = 38'h0000000010
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic run_in,
   output logic expired_out
);
   import sd_diag_pkg::*;

   typedef struct packed {
      logic [WARN_W-1:0] count;
      logic expired;
   } timer_state_type;

   timer_state_type state;
   timer_state_type next_state;

   // ----------------------------------------------------------------
   // count while running, restart from zero whenever the cause leaves
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_state.expired = 1'b0;
      if (!run_in) begin
         next_state.count = '0;
      end else if (state.count >= LIMIT - 38'h0000000001) begin
         next_state.expired = 1'b1;
      end else begin
         next_state.count = state.count + 38'h0000000001;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign expired_out = state.expired;

endmodule

// *** rtl/safety_switch_serial_diagnostics.sv ***
// file: serial diagnostic and switch-off logic of a chained guard-door safety switch
//
// Function
// - Request and response bytes for other switches pass through this switch.
// - One request byte in, one response byte out per switch each frame.
// - Loss of gateway traffic never changes the safety output state.
// - A failure switches both safety outputs off at once.
// - Failure clears when cause gone and request bit 7 falls or guard opens.
// - Output failures clear only at the next release of the outputs.
// - Output, cross-wire and temperature warnings keep outputs on, switch them off after thirty minutes.
// - A warning clears by itself when its cause is gone.
// - Response bits 0,1,4,5: outputs on, actuator, enables, guard.
// - Response bit 6 warning, bit 7 failure with outputs off.
// - Warning byte flags outputs, cross-wire, temperature, internal, comm, voltage.
// - Failure byte flags outputs, cross-wire, temperature, target, internal.
// - A bit at one means the named condition is present.
// - Detailed diagnostic bytes are always available beside the response.
// - Outputs on only with guard closed, actuator in, both enables active.
`timescale 1ns/1ns
module safety_switch_serial_diagnostics #(
   parameter logic [37:0] WARN_LIMIT = 38'(sd_diag_pkg::WARN_CYCLES),
   parameter logic [23:0] COMM_LIMIT = 24'(sd_diag_pkg::COMM_CYCLES)
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic guard_closed_in,
   input wire logic actuator_in,
   input wire logic enable_input_one_in,
   input wire logic enable_input_two_in,
   input wire logic out_one_err_in,
   input wire logic out_two_err_in,
   input wire logic cross_wire_in,
   input wire logic over_temp_in,
   input wire logic target_err_in,
   input wire logic internal_fail_in,
   input wire logic low_voltage_in,
   input wire logic frame_start_in,
   input wire logic req_valid_in,
   input wire logic [sd_diag_pkg::BYTE_W-1:0] req_data_in,
   output logic req_valid_out,
   output logic [sd_diag_pkg::BYTE_W-1:0] req_data_out,
   input wire logic rsp_valid_in,
   input wire logic [sd_diag_pkg::BYTE_W-1:0] rsp_data_in,
   output logic rsp_valid_out,
   output logic [sd_diag_pkg::BYTE_W-1:0] rsp_data_out,
   output logic safety_output_one_out,
   output logic safety_output_two_out,
   output logic [sd_diag_pkg::BYTE_W-1:0] switch_response_byte_out,
   output logic [sd_diag_pkg::BYTE_W-1:0] warning_diagnostic_byte_out,
   output logic [sd_diag_pkg::BYTE_W-1:0] failure_diagnostic_byte_out
);
   import sd_diag_pkg::*;

   typedef struct packed {
      logic outputs_on;
      logic [7:0] request;
      logic [7:0] response;
      logic [7:0] warn_diag;
      logic [7:0] fail_diag;
      logic clear_pending;
      logic [COMM_W-1:0] comm_count;
      logic comm_err;
      logic own_taken;
      logic req_fwd_valid;
      logic [7:0] req_fwd_data;
      logic send_own;
      logic rsp_fwd_valid;
      logic [7:0] rsp_fwd_data;
   } sw_state_type;

   sw_state_type state;
   sw_state_type next_state;
   logic timer_expired;
   logic [3:0] warn_cause;
   logic release_ok;
   logic clear_evt;
   logic bit7_fall;

   // ----------------------------------------------------------------
   // input conditions
   // ----------------------------------------------------------------
   // only the delayed-switch-off causes run the thirty-minute timer
   assign warn_cause = {over_temp_in, cross_wire_in, out_two_err_in, out_one_err_in};
   assign release_ok = guard_closed_in & actuator_in & enable_input_one_in
                       & enable_input_two_in;
   // falling edge of the reset bit, seen between two successive own request bytes;
   // a byte in the frame start cycle is forwarded, so it must never count here
   assign bit7_fall = req_valid_in & !frame_start_in & !state.own_taken
                      & state.request[REQ_RESET_BIT] & !req_data_in[REQ_RESET_BIT];
   assign clear_evt = bit7_fall | !guard_closed_in;

   // ----------------------------------------------------------------
   // warning persistence timer
   // ----------------------------------------------------------------
   warn_timer #(
      .LIMIT(WARN_LIMIT)
   ) u_warn_timer (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .run_in(|warn_cause),
      .expired_out(timer_expired)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;

      // chain link: first request byte of a frame is ours, the rest go on
      next_state.req_fwd_valid = 1'b0;
      next_state.rsp_fwd_valid = 1'b0;
      next_state.send_own = 1'b0;
      if (frame_start_in) begin
         next_state.own_taken = 1'b0;
         next_state.send_own = 1'b1;
      end
      if (req_valid_in) begin
         if (!state.own_taken && !frame_start_in) begin
            // only bit 7 is defined; the rest is dropped
            next_state.request = req_data_in & (8'h01 << REQ_RESET_BIT);
            next_state.own_taken = 1'b1;
         end else begin
            next_state.req_fwd_valid = 1'b1;
            next_state.req_fwd_data = req_data_in;
         end
      end
      // own response goes first; a downstream byte in that slot is lost
      if (state.send_own) begin
         next_state.rsp_fwd_valid = 1'b1;
         next_state.rsp_fwd_data = state.response;
      end else if (rsp_valid_in) begin
         next_state.rsp_fwd_valid = 1'b1;
         next_state.rsp_fwd_data = rsp_data_in;
      end

      // gateway silence only raises a flag, never touches the outputs
      if (frame_start_in) begin
         next_state.comm_count = '0;
         next_state.comm_err = 1'b0;
      end else if (state.comm_count >= COMM_LIMIT - 24'h000001) begin
         next_state.comm_err = 1'b1;
      end else begin
         next_state.comm_count = state.comm_count + 24'h000001;
      end

      // failure latch: clears first, sets afterwards so a new cause wins
      if (clear_evt) begin
         next_state.clear_pending = 1'b1;
         for (int i = DG_TEMP_BIT; i <= DG_INTERNAL_BIT; i++) begin
            if (i == DG_TEMP_BIT && !over_temp_in) begin
               next_state.fail_diag[i] = 1'b0;
            end else if (i == DG_TARGET_BIT && !target_err_in) begin
               next_state.fail_diag[i] = 1'b0;
            end else if (i == DG_INTERNAL_BIT && !internal_fail_in) begin
               next_state.fail_diag[i] = 1'b0;
            end
         end
      end
      // output faults wait for a fresh release request before they go
      if ((state.clear_pending || clear_evt) && release_ok) begin
         for (int i = DG_OUT_ONE_BIT; i <= DG_CROSS_BIT; i++) begin
            if (!warn_cause[i]) begin
               next_state.fail_diag[i] = 1'b0;
            end
         end
      end
      if (timer_expired) begin
         next_state.fail_diag[3:0] = next_state.fail_diag[3:0] | warn_cause;
      end
      next_state.fail_diag[DG_TARGET_BIT] = next_state.fail_diag[DG_TARGET_BIT]
                                            | target_err_in;
      next_state.fail_diag[DG_INTERNAL_BIT] = next_state.fail_diag[DG_INTERNAL_BIT]
                                              | internal_fail_in;
      next_state.fail_diag[7:6] = 2'b00;
      if ((next_state.fail_diag & OUTPUT_FAIL_MASK) == BYTE_RESET) begin
         next_state.clear_pending = 1'b0;
      end

      // warnings follow their causes with no latch
      next_state.warn_diag = BYTE_RESET;
      next_state.warn_diag[3:0] = warn_cause;
      next_state.warn_diag[DG_INTERNAL_BIT] = internal_fail_in;
      next_state.warn_diag[DG_COMM_BIT] = next_state.comm_err;
      next_state.warn_diag[DG_VOLT_BIT] = low_voltage_in;

      // enabling path: conditions present and no latched failure
      next_state.outputs_on = release_ok && (next_state.fail_diag == BYTE_RESET);

      next_state.response = BYTE_RESET;
      next_state.response[RSP_OUT_ON_BIT] = next_state.outputs_on;
      next_state.response[RSP_ACTUATOR_BIT] = actuator_in;
      next_state.response[RSP_ENABLES_BIT] = enable_input_one_in & enable_input_two_in;
      next_state.response[RSP_GUARD_BIT] = guard_closed_in;
      next_state.response[RSP_WARN_BIT] = |next_state.warn_diag;
      next_state.response[RSP_FAIL_BIT] = |next_state.fail_diag;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign safety_output_one_out = state.outputs_on;
   assign safety_output_two_out = state.outputs_on;
   assign switch_response_byte_out = state.response;
   assign warning_diagnostic_byte_out = state.warn_diag;
   assign failure_diagnostic_byte_out = state.fail_diag;
   assign req_valid_out = state.req_fwd_valid;
   assign req_data_out = state.req_fwd_data;
   assign rsp_valid_out = state.rsp_fwd_valid;
   assign rsp_data_out = state.rsp_fwd_data;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   a_fail_kills_out: assert property (
      (target_err_in || internal_fail_in) |=> !safety_output_one_out && !safety_output_two_out)
      else $error("safety outputs on after a failure");

   a_out_needs_cond: assert property (
      safety_output_one_out |-> $past(release_ok))
      else $error("safety outputs on without release conditions");

   a_fail_bit_sync: assert property (
      switch_response_byte_out[RSP_FAIL_BIT] |-> !safety_output_one_out)
      else $error("failure bit set while outputs on");

   a_fail_sticky: assert property (
      (failure_diagnostic_byte_out[DG_TARGET_BIT] && guard_closed_in && !bit7_fall)
      |=> failure_diagnostic_byte_out[DG_TARGET_BIT])
      else $error("target failure cleared without a reset event");

   a_warn_follows: assert property (
      $fell(over_temp_in) |=> !warning_diagnostic_byte_out[DG_TEMP_BIT])
      else $error("warning did not clear with its cause");

   a_warn_keeps_on: assert property (
      (release_ok && |warn_cause && !timer_expired && failure_diagnostic_byte_out == 8'h00
       && !target_err_in && !internal_fail_in) |=> safety_output_one_out)
      else $error("outputs dropped during warning before timeout");

   a_own_rsp_sent: assert property (
      frame_start_in |-> ##2 (rsp_valid_out && rsp_data_out == $past(switch_response_byte_out, 1)))
      else $error("own response byte not sent after frame start");

   a_req_forward: assert property (
      (req_valid_in && state.own_taken && !frame_start_in)
      |=> req_valid_out && req_data_out == $past(req_data_in))
      else $error("request byte not forwarded down the chain");

   a_reserved_zero: assert property (
      failure_diagnostic_byte_out[7:6] == 2'b00 && switch_response_byte_out[3:2] == 2'b00)
      else $error("undefined bits not zero");

   a_comm_no_effect: assert property (
      ($rose(state.comm_err) && $stable(release_ok) && !target_err_in && !internal_fail_in
       && !timer_expired && !clear_evt && !state.clear_pending)
      |=> $stable(safety_output_one_out))
      else $error("output changed on communication loss");

   // guards on the safety outputs and byte contents; all share the default clock and reset
   a_outs_equal: assert property (
      safety_output_one_out == safety_output_two_out)
      else $error("safety outputs disagree");

   a_target_latch: assert property (
      target_err_in |=> failure_diagnostic_byte_out[DG_TARGET_BIT])
      else $error("target failure not latched");

   a_guard_clears: assert property (
      (!guard_closed_in && !target_err_in)
      |=> !failure_diagnostic_byte_out[DG_TARGET_BIT])
      else $error("target failure kept with guard open and cause gone");

   a_volt_reported: assert property (
      low_voltage_in |=> warning_diagnostic_byte_out[DG_VOLT_BIT])
      else $error("low voltage not reported");

   a_frame_clears_comm: assert property (
      frame_start_in |=> !warning_diagnostic_byte_out[DG_COMM_BIT])
      else $error("link error flag kept after frame start");

   a_rsp_enables: assert property (
      (enable_input_one_in && enable_input_two_in) |=> switch_response_byte_out[RSP_ENABLES_BIT])
      else $error("enable inputs not reported");

endmodule

// *** bench/gateway_model.sv ***
// gateway and downstream chain model that drives and watches the diagnostic link
`timescale 1ns/1ns
module gateway_model (
   input wire logic clk_in,
   output logic frame_start_out,
   output logic req_valid_out,
   output logic [7:0] req_data_out,
   output logic rsp_valid_out,
   output logic [7:0] rsp_data_out,
   input wire logic req_valid_in,
   input wire logic [7:0] req_data_in,
   input wire logic rsp_valid_in,
   input wire logic [7:0] rsp_data_in
);
   logic [7:0] fwd_req[$];
   logic [7:0] fwd_rsp[$];
   logic [7:0] sent_req[$];
   logic [7:0] sent_rsp[$];

   // ----------------------------------------------------------------
   // link idles low; data lines show junk when not qualified
   // ----------------------------------------------------------------
   initial begin
      frame_start_out = 1'b0;
      req_valid_out = 1'b0;
      rsp_valid_out = 1'b0;
      req_data_out = 8'h5A;
      rsp_data_out = 8'hA5;
   end

   // collect what the switch passes on toward each side
   always @(posedge clk_in) begin
      if (req_valid_in === 1'b1) fwd_req.push_back(req_data_in);
      if (rsp_valid_in === 1'b1) fwd_rsp.push_back(rsp_data_in);
   end

   // one frame: own request, cnt downstream bytes (at most 30), responses lag cycles late
   task automatic run_frame(input logic [7:0] own, input int cnt, input int lag);
      int n;
      n = (cnt > 30) ? 30 : cnt;
      fwd_req.delete();
      fwd_rsp.delete();
      sent_req.delete();
      sent_rsp.delete();
      for (int c = 0; c <= n + lag + 1; c++) begin
         @(negedge clk_in);
         frame_start_out = (c == 0);
         req_valid_out = (c >= 1 && c <= n + 1);
         req_data_out = (c == 1) ? own : (req_valid_out ? 8'($urandom) : ~req_data_out);
         if (c >= 2 && req_valid_out) sent_req.push_back(req_data_out);
         // downstream answers never land in the cycle right after the start
         rsp_valid_out = (c >= lag + 2 && c < lag + 2 + n);
         rsp_data_out = rsp_valid_out ? 8'($urandom) : ~rsp_data_out;
         if (rsp_valid_out) sent_rsp.push_back(rsp_data_out);
      end
      @(negedge clk_in);
      frame_start_out = 1'b0;
      req_valid_out = 1'b0;
      rsp_valid_out = 1'b0;
      req_data_out = ~req_data_out;
      rsp_data_out = ~rsp_data_out;
      repeat (3) @(negedge clk_in);
   endtask
endmodule

// *** bench/tb.sv ***
// self-checking bench for the serial diagnostic block of the safety switch
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
   import sd_diag_pkg::*;
   localparam int WL = 20;
   localparam int CL = 1000;
   logic clk_in, arst_n_in, guard, act, en1, en2, target_err, internal_fail, low_volt;
   logic [3:0] delayed;
   logic fs, rq_v, rs_v, dq_v, ds_v, out_one, out_two;
   logic [7:0] rq_d, rs_d, dq_d, ds_d, rsp_byte, warn_byte, fail_byte;
   int mismatches = 0;
   int samples_checked = 0;
   int cnt;

   // ----------------------------------------------------------------
   // clock, design and link partner
   // ----------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   safety_switch_serial_diagnostics #(.WARN_LIMIT(38'h0000000014), .COMM_LIMIT(24'h0003E8)) DUT (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .guard_closed_in(guard), .actuator_in(act),
      .enable_input_one_in(en1), .enable_input_two_in(en2), .out_one_err_in(delayed[0]),
      .out_two_err_in(delayed[1]), .cross_wire_in(delayed[2]), .over_temp_in(delayed[3]),
      .target_err_in(target_err), .internal_fail_in(internal_fail), .low_voltage_in(low_volt),
      .frame_start_in(fs), .req_valid_in(rq_v), .req_data_in(rq_d), .req_valid_out(dq_v),
      .req_data_out(dq_d), .rsp_valid_in(rs_v), .rsp_data_in(rs_d), .rsp_valid_out(ds_v),
      .rsp_data_out(ds_d), .safety_output_one_out(out_one), .safety_output_two_out(out_two),
      .switch_response_byte_out(rsp_byte), .warning_diagnostic_byte_out(warn_byte),
      .failure_diagnostic_byte_out(fail_byte));

   gateway_model gw (
      .clk_in(clk_in), .frame_start_out(fs), .req_valid_out(rq_v), .req_data_out(rq_d),
      .rsp_valid_out(rs_v), .rsp_data_out(rs_d), .req_valid_in(dq_v), .req_data_in(dq_d),
      .rsp_valid_in(ds_v), .rsp_data_in(ds_d));

   // ----------------------------------------------------------------
   // expectations and helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] exp_rsp(input logic w, input logic f);
      logic on;
      on = guard & act & en1 & en2 & ~f;
      return {f, w, guard, en1 & en2, 2'b00, act, on};
   endfunction

   task automatic tick(input int k);
      repeat (k) @(negedge clk_in);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // which 0 waits for the outputs to drop, 1 for the link error flag
   task automatic bounded(input int lim, input int which, output int n);
      n = 0;
      while (n < lim && ((which == 0) ? (out_one === 1'b1) : (warn_byte[6] !== 1'b1))) begin
         tick(1);
         n++;
      end
      if (n >= lim) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, n, lim);
         conclude();
      end
   endtask

   task automatic check_state(input logic w, input logic f, input logic [7:0] wb,
                              input logic [7:0] fb);
      logic [7:0] e;
      e = exp_rsp(w, f);
      `CHK(rsp_byte, e)
      `CHK(out_one, e[0])
      `CHK(out_two, e[0])
      `CHK(warn_byte, wb)
      `CHK(fail_byte, fb)
   endtask

   task automatic frame(input logic [7:0] own, input int n, input int lag, input logic [7:0] eo);
      gw.run_frame(own, n, lag);
      `CHK(gw.fwd_req.size(), gw.sent_req.size())
      `CHK(gw.fwd_rsp.size(), gw.sent_rsp.size() + 1)
      `CHK(gw.fwd_rsp[0], eo)
      foreach (gw.sent_req[i]) `CHK(gw.fwd_req[i], gw.sent_req[i])
      foreach (gw.sent_rsp[i]) `CHK(gw.fwd_rsp[i + 1], gw.sent_rsp[i])
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      arst_n_in = 1'b0;
      {guard, act, en1, en2, target_err, internal_fail, low_volt} = 7'h00;
      delayed = 4'h0;
      cnt = $urandom(41);
      repeat (8) @(posedge clk_in);
      @(negedge clk_in);
      check_state(1'b0, 1'b0, 8'h00, 8'h00);
      arst_n_in = 1'b1;
      tick(2);
      // random switch states, full and random chain lengths, slow answers
      for (int i = 0; i < 24; i++) begin
         {guard, act, en1, en2} = (i < 2) ? 4'hF : 4'($urandom);
         tick(2);
         check_state(1'b0, 1'b0, 8'h00, 8'h00);
         frame(8'($urandom), (i == 0) ? 30 : $urandom_range(30), $urandom_range(3),
               exp_rsp(1'b0, 1'b0));
      end
      $display("test random states done");
      // delayed causes: warn, self clear, then time out and latch
      {guard, act, en1, en2} = 4'hF;
      for (int b = 0; b < 4; b++) begin
         delayed = 4'h1 << b;
         tick(3);
         check_state(1'b1, 1'b0, 8'h01 << b, 8'h00);
         delayed = 4'h0;
         tick(3);
         check_state(1'b0, 1'b0, 8'h00, 8'h00);
         delayed = 4'h1 << b;
         bounded(WL + 10, 0, cnt);
         `CHK((cnt >= WL) && (cnt <= WL + 2), 1'b1)
         delayed = 4'h0;
         tick(3);
         check_state(1'b0, 1'b1, 8'h00, 8'h01 << b);
         guard = 1'b0;
         tick(2);
         guard = 1'b1;
         tick(3);
         check_state(1'b0, 1'b0, 8'h00, 8'h00);
      end
      $display("test delayed causes done");
      // immediate causes, cleared by request bit fall and by guard opening
      target_err = 1'b1;
      tick(2);
      `CHK(out_one, 1'b0)
      `CHK(fail_byte, 8'h10)
      target_err = 1'b0;
      tick(2);
      check_state(1'b0, 1'b1, 8'h00, 8'h10);
      frame(8'h80, 2, 0, exp_rsp(1'b0, 1'b1));
      frame(8'h00, 2, 1, exp_rsp(1'b0, 1'b1));
      tick(2);
      check_state(1'b0, 1'b0, 8'h00, 8'h00);
      internal_fail = 1'b1;
      tick(2);
      `CHK(out_two, 1'b0)
      `CHK({warn_byte, fail_byte, rsp_byte[7]}, {8'h20, 8'h20, 1'b1})
      internal_fail = 1'b0;
      tick(2);
      guard = 1'b0;
      tick(2);
      `CHK(fail_byte, 8'h00)
      guard = 1'b1;
      tick(3);
      check_state(1'b0, 1'b0, 8'h00, 8'h00);
      // guard opened while the cause stands: the latch holds until the cause goes
      target_err = 1'b1;
      tick(2);
      guard = 1'b0;
      tick(2);
      `CHK(fail_byte, 8'h10)
      target_err = 1'b0;
      tick(2);
      `CHK(fail_byte, 8'h00)
      guard = 1'b1;
      tick(3);
      check_state(1'b0, 1'b0, 8'h00, 8'h00);
      $display("test immediate causes done");
      // link silence keeps the outputs as they are
      low_volt = 1'b1;
      bounded(CL + 20, 1, cnt);
      `CHK(out_one, 1'b1)
      `CHK(warn_byte, 8'hC0)
      check_state(1'b1, 1'b0, 8'hC0, 8'h00);
      low_volt = 1'b0;
      gw.run_frame(8'h00, 1, 0);
      tick(2);
      check_state(1'b0, 1'b0, 8'h00, 8'h00);
      $display("test link loss done");
      conclude();
   end
endmodule
